// ### rtl/artc_pkg.sv
/*
  Constants shared by the auto-reload timer/counter: register offsets,
  control field positions, reset values and machine cycle timing.
  Assumes a 32-bit APB bus with byte addresses.
*/
package artc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ARTC_OFS_CTRL     = 8'h00;
  localparam logic [7:0] ARTC_OFS_CNT_LO   = 8'h04;
  localparam logic [7:0] ARTC_OFS_CNT_HI   = 8'h08;
  localparam logic [7:0] ARTC_OFS_RLD_LO   = 8'h0c;
  localparam logic [7:0] ARTC_OFS_RLD_HI   = 8'h10;
  localparam logic [7:0] ARTC_OFS_STATUS   = 8'h14;
  localparam logic [7:0] ARTC_OFS_IRQ_EN   = 8'h18;
  localparam logic [7:0] ARTC_OFS_IRQ_CLR  = 8'h1c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int ARTC_CTRL_GATE   = 7;
  localparam int ARTC_CTRL_SRC    = 6;
  localparam int ARTC_CTRL_OVF    = 5;
  localparam int ARTC_CTRL_RUN    = 4;
  localparam int ARTC_CTRL_EXTA_F = 3;
  localparam int ARTC_CTRL_EXTA_T = 2;
  localparam int ARTC_CTRL_EXTB_F = 1;
  localparam int ARTC_CTRL_EXTB_T = 0;

  // ----------------------------------------------------------------
  // Status, enable and clear layout
  // ----------------------------------------------------------------
  localparam int ARTC_ST_OVF  = 0;
  localparam int ARTC_ST_EXTA = 1;
  localparam int ARTC_ST_EXTB = 2;
  localparam int ARTC_ST_W    = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]          ARTC_RST_BYTE   = 8'h00;
  localparam logic [ARTC_ST_W-1:0] ARTC_RST_IRQ_EN = 3'h0;
  localparam logic                ARTC_PIN_IDLE   = 1'b1;

  // ----------------------------------------------------------------
  // Machine cycle timing
  // ----------------------------------------------------------------
  localparam int         ARTC_MC_CLKS     = 12;
  localparam logic [3:0] ARTC_MC_LAST     = 4'(ARTC_MC_CLKS - 1);
  localparam logic [3:0] ARTC_SAMPLE_PHASE = 4'h6;

endpackage

// ### rtl/artc_pin_sync.sv
/*
  Three-stage pin synchroniser with a two-sample agreement filter.
  Assumes asynchronous inputs and a single destination clock.
*/
`timescale 1ns/100ps
module artc_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_level
);
  import artc_pkg::*;

  // ----------------------------------------------------------------
  // Per pin stages
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    // First stage feeds only the second
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        s1_q  <= ARTC_PIN_IDLE;
        s2_q  <= ARTC_PIN_IDLE;
        s3_q  <= ARTC_PIN_IDLE;
        lvl_q <= ARTC_PIN_IDLE;
      end else begin
        s1_q <= pin_async[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end
    end
    assign pin_level[i] = lvl_q;
  end

endmodule

// ### rtl/artc_top.sv
/*
  Auto-reload 16-bit timer/counter with two external interrupt detectors,
  an APB register slave and one level interrupt output.
  Assumes pins are asynchronous and one machine cycle is twelve clocks.
*/
`timescale 1ns/100ps

module artc_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_input_pin,
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  input  wire logic        timer_vector_ack,
  output logic             irq
);
  import artc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0]           phase_q;
  logic [7:0]           cnt_lo_q;
  logic [7:0]           cnt_hi_q;
  logic [7:0]           rld_lo_q;
  logic [7:0]           rld_hi_q;
  logic                 gate_q;
  logic                 src_q;
  logic                 run_bit_q;
  logic                 ext_irq_a_type_q;
  logic                 ext_irq_b_type_q;
  logic                 overflow_flag_q;
  logic                 ext_irq_a_flag_q;
  logic                 ext_irq_b_flag_q;
  logic [ARTC_ST_W-1:0] irq_en_q;
  logic                 samp_q;
  logic                 a_prev_q;
  logic                 b_prev_q;
  logic [31:0]          prdata_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_lvl;
  wire        cnt_lvl = pin_lvl[0];
  wire        a_lvl   = pin_lvl[1];
  wire        b_lvl   = pin_lvl[2];

  artc_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin_async ({ext_irq_b_pin, ext_irq_a_pin, count_input_pin}),
    .pin_level (pin_lvl)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire hit_ctrl = paddr == ARTC_OFS_CTRL;
  wire hit_clo  = paddr == ARTC_OFS_CNT_LO;
  wire hit_chi  = paddr == ARTC_OFS_CNT_HI;
  wire hit_rlo  = paddr == ARTC_OFS_RLD_LO;
  wire hit_rhi  = paddr == ARTC_OFS_RLD_HI;
  wire hit_st   = paddr == ARTC_OFS_STATUS;
  wire hit_en   = paddr == ARTC_OFS_IRQ_EN;
  wire hit_clr  = paddr == ARTC_OFS_IRQ_CLR;
  wire hit_any  = hit_ctrl | hit_clo | hit_chi | hit_rlo | hit_rhi
                | hit_st | hit_en | hit_clr;
  wire wr       = access & pwrite;
  wire wr_ctrl  = wr & hit_ctrl;
  wire wr_clo   = wr & hit_clo;
  wire wr_chi   = wr & hit_chi;
  wire wr_rlo   = wr & hit_rlo;
  wire wr_rhi   = wr & hit_rhi;
  wire wr_en    = wr & hit_en;
  wire [ARTC_ST_W-1:0] clr_bits = (wr & hit_clr) ? pwdata[ARTC_ST_W-1:0] : '0;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = access;
  assign pslverr = access & ~hit_any;
  assign prdata  = prdata_q;

  // ----------------------------------------------------------------
  // Machine cycle and count source
  // ----------------------------------------------------------------
  wire [15:0] count  = {cnt_hi_q, cnt_lo_q};
  wire [15:0] reload = {rld_hi_q, rld_lo_q};
  wire mc_end        = phase_q == ARTC_MC_LAST;
  wire samp_now      = phase_q == ARTC_SAMPLE_PHASE;
  wire cnt_edge      = samp_now & samp_q & ~cnt_lvl;
  wire run_ok        = run_bit_q & (~gate_q | a_lvl);
  wire src_tick      = src_q ? cnt_edge : mc_end;
  wire tick          = run_ok & src_tick;
  wire wrap          = tick & (count == 16'hffff);
  wire [15:0] cnt_inc = 16'(count + 16'h0001);
  wire [15:0] cnt_nxt = wrap ? reload : (tick ? cnt_inc : count);
  wire [3:0]  phase_d = mc_end ? 4'h0 : 4'(phase_q + 4'h1);

  // ----------------------------------------------------------------
  // Flag events
  // ----------------------------------------------------------------
  // pin A detect
  wire set_a   = ext_irq_a_type_q ? (a_prev_q & ~a_lvl) : ~a_lvl;
  wire set_b   = ext_irq_b_type_q ? (b_prev_q & ~b_lvl) : ~b_lvl;
  wire clr_ovf = timer_vector_ack | clr_bits[ARTC_ST_OVF];
  wire [ARTC_ST_W-1:0] status = {ext_irq_b_flag_q, ext_irq_a_flag_q, overflow_flag_q};
  wire [7:0] ctrl_rd = {gate_q, src_q, overflow_flag_q, run_bit_q,
                        ext_irq_a_flag_q, ext_irq_a_type_q,
                        ext_irq_b_flag_q, ext_irq_b_type_q};

  assign irq = |(status & irq_en_q);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [7:0] rd_byte = hit_ctrl ? ctrl_rd
                     : hit_clo  ? cnt_lo_q
                     : hit_chi  ? cnt_hi_q
                     : hit_rlo  ? rld_lo_q
                     : hit_rhi  ? rld_hi_q
                     : hit_st   ? {5'h00, status}
                     : hit_en   ? {5'h00, irq_en_q}
                     : 8'h00;

  // ----------------------------------------------------------------
  // Sequencing and sampling
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_q     <= 4'h0;
      samp_q      <= ARTC_PIN_IDLE;
      a_prev_q    <= ARTC_PIN_IDLE;
      b_prev_q    <= ARTC_PIN_IDLE;
      prdata_q    <= 32'h0000_0000;
    end else begin
      phase_q  <= phase_d;
      a_prev_q <= a_lvl;
      b_prev_q <= b_lvl;
      if (samp_now) begin
        samp_q <= cnt_lvl;
      end
      // Read data latched in setup so it stands through access
      if (setup) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Count and reload registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_lo_q <= ARTC_RST_BYTE;
      cnt_hi_q <= ARTC_RST_BYTE;
      rld_lo_q <= ARTC_RST_BYTE;
      rld_hi_q <= ARTC_RST_BYTE;
    end else begin
      cnt_lo_q <= wr_clo ? pwdata[7:0] : cnt_nxt[7:0];
      cnt_hi_q <= wr_chi ? pwdata[7:0] : cnt_nxt[15:8];
      if (wr_rlo) begin
        rld_lo_q <= pwdata[7:0];
      end
      if (wr_rhi) begin
        rld_hi_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, flags and enables
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_q           <= 1'b0;
      src_q            <= 1'b0;
      run_bit_q        <= 1'b0;
      ext_irq_a_type_q <= 1'b0;
      ext_irq_b_type_q <= 1'b0;
      overflow_flag_q  <= 1'b0;
      ext_irq_a_flag_q <= 1'b0;
      ext_irq_b_flag_q <= 1'b0;
      irq_en_q         <= ARTC_RST_IRQ_EN;
    end else begin
      if (wr_ctrl) begin
        gate_q           <= pwdata[ARTC_CTRL_GATE];
        src_q            <= pwdata[ARTC_CTRL_SRC];
        run_bit_q        <= pwdata[ARTC_CTRL_RUN];
        ext_irq_a_type_q <= pwdata[ARTC_CTRL_EXTA_T];
        ext_irq_b_type_q <= pwdata[ARTC_CTRL_EXTB_T];
      end
      if (wr_en) begin
        irq_en_q <= pwdata[ARTC_ST_W-1:0];
      end
      overflow_flag_q  <= wrap  | (overflow_flag_q  & ~clr_ovf);
      ext_irq_a_flag_q <= set_a | (ext_irq_a_flag_q & ~clr_bits[ARTC_ST_EXTA]);
      ext_irq_b_flag_q <= set_b | (ext_irq_b_flag_q & ~clr_bits[ARTC_ST_EXTB]);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  wire cnt_wr = wr_clo | wr_chi;

  // edge gap counter
  // Cycles since the last counted pin edge, saturating
  logic [4:0] edge_gap_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      edge_gap_q <= 5'h1f;
    end else if (cnt_edge) begin
      edge_gap_q <= 5'h01;
    end else if (edge_gap_q != 5'h1f) begin
      edge_gap_q <= 5'(edge_gap_q + 5'h01);
    end
  end

  sequence s_a_fall;
    ext_irq_a_type_q && a_lvl ##1 !a_lvl;
  endsequence

  sequence s_b_fall;
    ext_irq_b_type_q && b_lvl ##1 !b_lvl;
  endsequence

  a_count_phase: assert property (
    src_q && !cnt_wr && phase_q != ARTC_SAMPLE_PHASE |=> $stable(count))
    else $error("count pin tick outside sample phase");

  a_gate_hold: assert property (
    gate_q && !a_lvl && !cnt_wr |=> count == $past(count))
    else $error("count moved while gated off");

  a_timer_rate: assert property (
    !src_q && run_ok && !cnt_wr && count != 16'hffff && mc_end
      |=> count == 16'($past(count) + 16'h0001))
    else $error("timer mode missed machine cycle tick");

  a_stop_hold: assert property (
    !run_bit_q && !cnt_wr |=> $stable(count))
    else $error("count moved while stopped");

  a_count_step: assert property (
    tick && !cnt_wr && count != 16'hffff |=> count == 16'($past(count) + 16'h0001))
    else $error("count did not increment on tick");

  a_reload_load: assert property (
    wrap && !cnt_wr |=> count == $past(reload))
    else $error("overflow did not load reload value");

  a_reload_kept: assert property (
    wrap && !wr_rlo && !wr_rhi |=> $stable(reload))
    else $error("reload changed by overflow");

  a_ovf_set: assert property (
    wrap |=> overflow_flag_q)
    else $error("overflow flag not set");

  a_ovf_ack: assert property (
    overflow_flag_q && timer_vector_ack && !wrap |=> !overflow_flag_q)
    else $error("overflow flag not cleared on vector");

  a_irq_req: assert property (
    overflow_flag_q && irq_en_q[ARTC_ST_OVF] |-> irq)
    else $error("timer request missing");

  a_ext_a_edge: assert property (
    s_a_fall |=> ext_irq_a_flag_q)
    else $error("pin A edge not flagged");

  a_ext_b_edge: assert property (
    s_b_fall |=> ext_irq_b_flag_q)
    else $error("pin B edge not flagged");

  a_edge_spacing: assert property (
    cnt_edge |=> !cnt_edge [*8])
    else $error("count pin edges too close");

  a_edge_gap: assert property (
    cnt_edge |-> edge_gap_q >= 5'(2 * ARTC_MC_CLKS))
    else $error("count pin edges under two machine cycles apart");

endmodule

// ### sim/artc_pin_src.sv
/*
  Pin source model for the count pin and the two interrupt pins.
  Assumes pins idle high and a machine cycle of ARTC_MC_CLKS clocks.
*/
`timescale 1ns/100ps
module artc_pin_src (
  input  wire logic ref_clk,
  output logic      count_input_pin,
  output logic      ext_irq_a_pin,
  output logic      ext_irq_b_pin
);
  import artc_pkg::*;

  initial begin
    count_input_pin = ARTC_PIN_IDLE;
    ext_irq_a_pin   = ARTC_PIN_IDLE;
    ext_irq_b_pin   = ARTC_PIN_IDLE;
  end

  task automatic set_a(input logic v);
    @(posedge ref_clk);
    ext_irq_a_pin <= v;
  endtask

  task automatic set_b(input logic v);
    @(posedge ref_clk);
    ext_irq_b_pin <= v;
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      count_input_pin <= 1'b0;
      repeat (3 * ARTC_MC_CLKS) @(posedge ref_clk);
      count_input_pin <= 1'b1;
      repeat (3 * ARTC_MC_CLKS) @(posedge ref_clk);
    end
  endtask
endmodule

// ### sim/tb.sv
/*
  Self-checking bench for the auto-reload timer/counter.
  Assumes artc_pkg, artc_top and artc_pin_src are compiled first.
*/
`timescale 1ns/100ps
module tb;
  import artc_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        count_input_pin;
  logic        ext_irq_a_pin;
  logic        ext_irq_b_pin;
  logic        timer_vector_ack;
  logic        irq;
  logic [32:0] exp_q[$];
  logic [7:0]  rst_ofs [6];
  logic [15:0] rld;
  logic [7:0]  npul;
  int          mismatches;
  int          n_checks;

  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;

  artc_top artc_top_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_input_pin(count_input_pin), .ext_irq_a_pin(ext_irq_a_pin),
    .ext_irq_b_pin(ext_irq_b_pin), .timer_vector_ack(timer_vector_ack), .irq(irq));

  artc_pin_src artc_pin_src_i (.ref_clk(ref_clk), .count_input_pin(count_input_pin),
    .ext_irq_a_pin(ext_irq_a_pin), .ext_irq_b_pin(ext_irq_b_pin));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    mismatches++;
    $display("FAIL %0t %s", $time, m);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Wait ends once pready is seen high
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic err);
    exp_q.push_back({err, 24'h0, d});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic cmp_rd(input logic [32:0] e);
    n_checks++;
    if (pslverr !== e[32] || (!e[32] && prdata !== e[31:0])) fail("read data");
  endtask

  task automatic cmp_irq(input logic e);
    n_checks++;
    if (irq !== e) fail("irq level");
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic conclude();
    $display("mismatches=%0d n_checks=%0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Read monitor takes the oldest note
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) fail("unexpected read");
      else cmp_rd(exp_q.pop_front());
    end
  end

  // Run is under 800 clocks; generous margin
  initial begin
    #200000;
    fail("timeout");
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer_vector_ack = 1'b0;
    mismatches = 0;
    n_checks = 0;
    rst_ofs = '{ARTC_OFS_CTRL, ARTC_OFS_CNT_LO, ARTC_OFS_CNT_HI, ARTC_OFS_RLD_LO,
                ARTC_OFS_RLD_HI, ARTC_OFS_IRQ_EN};
    void'($urandom(54832));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rst_ofs[i]) rd(rst_ofs[i], 8'h00, 1'b0);
    rd(8'h20, 8'h00, 1'b1);
    cmp_irq(1'b0);
    // Timer mode wrap from ffff
    rld = 16'($urandom() & 32'h7fff);
    wr(ARTC_OFS_RLD_LO, rld[7:0]);
    wr(ARTC_OFS_RLD_HI, rld[15:8]);
    wr(ARTC_OFS_CNT_LO, 8'hff);
    wr(ARTC_OFS_CNT_HI, 8'hff);
    wr(ARTC_OFS_IRQ_EN, 8'h01);
    wr(ARTC_OFS_CTRL, 8'h10);
    wait_irq(30);
    cmp_irq(1'b1);
    wr(ARTC_OFS_CTRL, 8'h00);
    rd(ARTC_OFS_CNT_LO, rld[7:0], 1'b0);
    rd(ARTC_OFS_CNT_HI, rld[15:8], 1'b0);
    rd(ARTC_OFS_RLD_LO, rld[7:0], 1'b0);
    rd(ARTC_OFS_RLD_HI, rld[15:8], 1'b0);
    rd(ARTC_OFS_CTRL, 8'h20, 1'b0);
    wr(ARTC_OFS_STATUS, 8'h00);
    rd(ARTC_OFS_STATUS, 8'h01, 1'b0);
    @(posedge ref_clk) timer_vector_ack <= 1'b1;
    @(posedge ref_clk) timer_vector_ack <= 1'b0;
    @(posedge ref_clk);
    cmp_irq(1'b0);
    rd(ARTC_OFS_STATUS, 8'h00, 1'b0);
    // Gate held low by pin A, level mode
    wr(ARTC_OFS_CNT_LO, 8'hff);
    wr(ARTC_OFS_CNT_HI, 8'hff);
    artc_pin_src_i.set_a(1'b0);
    repeat (8) @(posedge ref_clk);
    wr(ARTC_OFS_CTRL, 8'h90);
    repeat (40) @(posedge ref_clk);
    rd(ARTC_OFS_CNT_LO, 8'hff, 1'b0);
    rd(ARTC_OFS_STATUS, 8'h02, 1'b0);
    artc_pin_src_i.set_a(1'b1);
    wait_irq(40);
    cmp_irq(1'b1);
    wr(ARTC_OFS_CTRL, 8'h00);
    wr(ARTC_OFS_IRQ_CLR, 8'h03);
    rd(ARTC_OFS_STATUS, 8'h00, 1'b0);
    // Pin B edge mode, masked then enabled
    wr(ARTC_OFS_CTRL, 8'h01);
    artc_pin_src_i.set_b(1'b0);
    repeat (8) @(posedge ref_clk);
    rd(ARTC_OFS_STATUS, 8'h04, 1'b0);
    cmp_irq(1'b0);
    wr(ARTC_OFS_IRQ_EN, 8'h04);
    @(posedge ref_clk);
    cmp_irq(1'b1);
    wr(ARTC_OFS_IRQ_CLR, 8'h04);
    repeat (4) @(posedge ref_clk);
    cmp_irq(1'b0);
    // Pin A edge mode, pin B level mode
    wr(ARTC_OFS_CTRL, 8'h04);
    artc_pin_src_i.set_a(1'b0);
    repeat (8) @(posedge ref_clk);
    rd(ARTC_OFS_STATUS, 8'h06, 1'b0);
    wr(ARTC_OFS_IRQ_CLR, 8'h06);
    rd(ARTC_OFS_CTRL, 8'h06, 1'b0);
    cmp_irq(1'b1);
    artc_pin_src_i.set_a(1'b1);
    artc_pin_src_i.set_b(1'b1);
    repeat (8) @(posedge ref_clk);
    wr(ARTC_OFS_IRQ_CLR, 8'h04);
    rd(ARTC_OFS_STATUS, 8'h00, 1'b0);
    // Counter mode from the count pin
    npul = 8'(1 + ($urandom() % 6));
    wr(ARTC_OFS_CNT_LO, 8'h00);
    wr(ARTC_OFS_CNT_HI, 8'h00);
    wr(ARTC_OFS_CTRL, 8'h50);
    artc_pin_src_i.pulses(int'(npul));
    wr(ARTC_OFS_CTRL, 8'h00);
    rd(ARTC_OFS_CNT_LO, npul, 1'b0);
    rd(ARTC_OFS_CNT_HI, 8'h00, 1'b0);
    repeat (2) @(posedge ref_clk);
    if (exp_q.size() != 0) fail("reads left over");
    conclude();
  end
endmodule
